// ===== design/bftm_unit.v
// Bit-field test-and-change / test-and-clear datapath with Wishbone registers
`include "bftm_regs.vh"
module bftm_unit (
  // Clock and reset
  input wire sys_clk,
  input wire rst_b,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Destination access port
  output reg dst_req,
  output reg dst_we,
  output reg [1:0] dst_space,
  output reg [15:0] dst_addr,
  output reg [15:0] dst_wdata,
  input wire [15:0] dst_rdata,
  // Limiting report from the source move
  input wire lim_event
);

  // Software-visible state
  reg [15:0] mask;
  reg [15:0] opnd;
  reg [15:0] ptr_base;
  reg [15:0] stk_ptr;
  reg [15:0] status_word;
  reg op_clr;
  reg [2:0] mode;
  reg fault;
  reg [3:0] last_cyc;
  reg [1:0] last_wrd;

  // Sequencer state, one-hot
  localparam ST_IDLE = 2'b01;
  localparam ST_RUN = 2'b10;
  reg [1:0] state;
  reg [3:0] cnt;
  reg [3:0] total;
  reg [15:0] rd_val;
  reg lim_seen;

  // Bus decode
  wire wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_hit & wb_we_i & wb_sel_i[0] & wb_sel_i[1];
  wire busy = state[1];

  // Core register destination test, shared by status word and stack checks
  function reg_is;
    input [2:0] md;
    input [4:0] code;
    input [4:0] want;
    begin
      reg_is = (md == `BFTM_MODE_REG) && (code == want);
    end
  endfunction

  // Status word as destination is handled inside the unit
  wire sw_dest = reg_is(mode, opnd[4:0], `BFTM_CODE_SW); // RULE7

  // Mask test for ordinary destinations only; modify shared by every destination kind
  function all_set;
    input [15:0] val;
    input [15:0] msk;
    begin
      all_set = ((val & msk) == msk); // RULE2 RULE5
    end
  endfunction

  function [15:0] modify;
    input [15:0] val;
    input [15:0] msk;
    input clr;
    begin
      if (clr) begin
        modify = val & ~msk; // RULE4
      end else begin
        modify = val ^ msk; // RULE3
      end
    end
  endfunction

  // Effective address per addressing form
  reg [15:0] ea;
  reg [1:0] space;
  reg [16:0] idx_sum; // Carry of indexed sums dropped; addresses wrap
  always @* begin
    ea = opnd;
    space = `BFTM_SPACE_DATA;
    idx_sum = 17'h0_0000;
    case (mode)
      `BFTM_MODE_REG: begin
        ea = {11'h000, opnd[4:0]};
        space = `BFTM_SPACE_CREG;
      end
      `BFTM_MODE_SDIR: begin
        ea = {10'h000, opnd[5:0]}; // RULE9
      end
      `BFTM_MODE_SPER: begin
        ea = `BFTM_PERI_BASE | {10'h000, opnd[5:0]}; // RULE10
        space = `BFTM_SPACE_PERI;
      end
      `BFTM_MODE_PIDX: begin
        idx_sum = {1'b0, ptr_base} + {1'b0, opnd};
        ea = idx_sum[15:0];
      end
      `BFTM_MODE_SIDX: begin
        idx_sum = {1'b0, stk_ptr} - {1'b0, opnd};
        ea = idx_sum[15:0];
      end
      default: begin
        ea = opnd;
      end
    endcase
  end

  // Cycle and word count of an addressing form
  function [3:0] form_cycles;
    input [2:0] md;
    begin
      case (md)
        `BFTM_MODE_PIDX, `BFTM_MODE_SIDX, `BFTM_MODE_LONG: begin
          form_cycles = `BFTM_CYC_LONG; // RULE11
        end
        default: begin
          form_cycles = `BFTM_CYC_SHORT; // RULE11
        end
      endcase
    end
  endfunction

  // Only the long absolute form carries a third word
  function [1:0] form_words;
    input [2:0] md;
    begin
      if (md == `BFTM_MODE_LONG) begin
        form_words = `BFTM_WRD_LONG; // RULE11
      end else begin
        form_words = `BFTM_WRD_SHORT;
      end
    end
  endfunction

  // Count of a requested form, taken with the start write
  wire [2:0] req_mode = wb_dat_i[`BFTM_CTRL_MODE_HI:`BFTM_CTRL_MODE_LO];
  wire [3:0] req_total = form_cycles(req_mode);
  wire [1:0] req_words = form_words(req_mode);
  wire start = wb_wr && (wb_adr_i == `BFTM_OFS_CTRL) && wb_dat_i[`BFTM_CTRL_START] &&
    !busy && (req_mode <= `BFTM_MODE_LONG);

  // Phase marks inside the run: read issue, data capture with write issue, run end
  wire ph_read = busy && (cnt == total - `BFTM_PH_READ);
  wire ph_capt = busy && (cnt == total - `BFTM_PH_CAPT);
  wire ph_done = busy && (cnt == total - `BFTM_PH_DONE);
  wire [15:0] cur_val = sw_dest ? status_word : dst_rdata;

  // Next sequencer state; a run always lasts its full count
  reg [1:0] next_state;
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (ph_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Sequencer and destination port
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      cnt <= 4'h0;
      total <= `BFTM_CYC_SHORT;
      rd_val <= 16'h0000;
      lim_seen <= 1'b0;
      dst_req <= 1'b0;
      dst_we <= 1'b0;
      dst_space <= `BFTM_SPACE_DATA;
      dst_addr <= 16'h0000;
      dst_wdata <= 16'h0000;
      last_cyc <= 4'h0;
      last_wrd <= 2'h0;
    end else begin
      dst_req <= 1'b0;
      dst_we <= 1'b0;
      state <= next_state;
      case (state)
        ST_IDLE: begin
          cnt <= 4'h0;
          lim_seen <= 1'b0;
          if (start) begin
            total <= req_total;
            last_cyc <= req_total;
            last_wrd <= req_words;
          end
        end
        ST_RUN: begin
          cnt <= cnt + 4'h1;
          // Limiting may be reported any time during the move
          if (lim_event) begin
            lim_seen <= 1'b1;
          end
          // Status word destination never touches the port
          if (ph_read && !sw_dest) begin
            dst_req <= 1'b1; // RULE12
            dst_space <= space;
            dst_addr <= ea;
          end
          if (ph_capt) begin
            rd_val <= cur_val;
            if (!sw_dest) begin
              dst_req <= 1'b1; // RULE12
              dst_we <= 1'b1;
              dst_wdata <= modify(cur_val, mask, op_clr); // RULE1 RULE3 RULE4 RULE5
            end
          end
        end
        default: begin
          cnt <= 4'h0;
        end
      endcase
    end
  end

  // Software registers; hardware update of the status word wins over a write
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      mask <= 16'h0000;
      opnd <= 16'h0000;
      ptr_base <= 16'h0000;
      stk_ptr <= 16'h0000;
      status_word <= `BFTM_SW_RESET;
      op_clr <= 1'b0;
      mode <= `BFTM_MODE_REG;
      fault <= 1'b0;
    end else begin
      // Operand registers are frozen while a run uses them
      if (wb_wr && !busy) begin
        case (wb_adr_i)
          `BFTM_OFS_MASK: mask <= wb_dat_i[15:0];
          `BFTM_OFS_OPND: opnd <= wb_dat_i[15:0];
          `BFTM_OFS_PTR: ptr_base <= wb_dat_i[15:0];
          `BFTM_OFS_SP: stk_ptr <= wb_dat_i[15:0];
          `BFTM_OFS_SW: status_word <= wb_dat_i[15:0];
          default: begin
          end
        endcase
      end
      if (start) begin
        op_clr <= wb_dat_i[`BFTM_CTRL_OP];
        mode <= req_mode;
        // Stack register as destination is a software fault; flagged, not blocked
        fault <= reg_is(req_mode, opnd[4:0], `BFTM_CODE_HWS); // RULE8
      end
      if (ph_done) begin
        if (sw_dest) begin
          status_word <= modify(rd_val, mask, op_clr); // RULE7
        end else begin
          // Only carry and limit move for ordinary destinations
          status_word[`BFTM_SW_C] <= all_set(rd_val, mask); // RULE2 RULE5 RULE13
          if (lim_seen || lim_event) begin
            status_word[`BFTM_SW_L] <= 1'b1; // RULE6
          end
        end
      end
    end
  end

  // Wishbone answer: ack one cycle after the request, unmapped reads zero
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit) begin
        case (wb_adr_i)
          `BFTM_OFS_CTRL: wb_dat_o <= {27'h000_0000, mode, op_clr, 1'b0};
          `BFTM_OFS_MASK: wb_dat_o <= {16'h0000, mask};
          `BFTM_OFS_OPND: wb_dat_o <= {16'h0000, opnd};
          `BFTM_OFS_PTR: wb_dat_o <= {16'h0000, ptr_base};
          `BFTM_OFS_SP: wb_dat_o <= {16'h0000, stk_ptr};
          `BFTM_OFS_SW: wb_dat_o <= {16'h0000, status_word};
          `BFTM_OFS_STAT: wb_dat_o <= {14'h0000, last_wrd, 4'h0, last_cyc, 6'h00, fault, busy};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // bftm_unit

// ===== design/bftm_regs.vh
// Constants and register map of the bit-field test-and-modify unit
// Function
// RULE1 - 16-bit mask selects destination bits
// RULE2 - Carry set when all selected bits one
// RULE3 - Toggle variant inverts selected bits, writes back
// RULE4 - Clear variant zeroes selected bits, writes back
// RULE5 - Zero mask: destination unchanged, carry set
// RULE6 - Limit flag set on limiting source move
// RULE7 - Status word destination: field modifies flags
// RULE8 - Software never names hardware stack register
// RULE9 - Short direct form: 6-bit data address
// RULE10 - Short peripheral form: 6-bit peripheral address
// RULE11 - Cycles/words: 4/2, indexed 6/2, long 6/3
// RULE12 - One read then one write per operation
// RULE13 - Other flags untouched for normal destinations
`ifndef BFTM_REGS_VH
`define BFTM_REGS_VH
// Wishbone byte offsets
`define BFTM_OFS_CTRL 8'h00
`define BFTM_OFS_MASK 8'h04
`define BFTM_OFS_OPND 8'h08
`define BFTM_OFS_PTR 8'h0C
`define BFTM_OFS_SP 8'h10
`define BFTM_OFS_SW 8'h14
`define BFTM_OFS_STAT 8'h18
// Control fields
`define BFTM_CTRL_START 0
`define BFTM_CTRL_OP 1
`define BFTM_CTRL_MODE_LO 2
`define BFTM_CTRL_MODE_HI 4
// Status register fields
`define BFTM_STAT_BUSY 0
`define BFTM_STAT_FAULT 1
`define BFTM_STAT_CYC_LO 8
`define BFTM_STAT_CYC_HI 11
`define BFTM_STAT_WRD_LO 16
`define BFTM_STAT_WRD_HI 17
// Addressing modes
`define BFTM_MODE_REG 3'h0
`define BFTM_MODE_SDIR 3'h1
`define BFTM_MODE_SPER 3'h2
`define BFTM_MODE_PIDX 3'h3
`define BFTM_MODE_SIDX 3'h4
`define BFTM_MODE_LONG 3'h5
// Destination spaces
`define BFTM_SPACE_DATA 2'h0
`define BFTM_SPACE_PERI 2'h1
`define BFTM_SPACE_CREG 2'h2
// Register codes and peripheral region base
`define BFTM_CODE_SW 5'h19
`define BFTM_CODE_HWS 5'h1F
`define BFTM_PERI_BASE 16'hFFC0
// Status word flag positions and reset
`define BFTM_SW_C 0
`define BFTM_SW_L 6
`define BFTM_SW_RESET 16'h0000
// Cycle and word counts
`define BFTM_CYC_SHORT 4'h4
`define BFTM_CYC_LONG 4'h6
`define BFTM_WRD_SHORT 2'h2
`define BFTM_WRD_LONG 2'h3
// Run phases, counted back from the end of the run
`define BFTM_PH_READ 4'h4
`define BFTM_PH_CAPT 4'h2
`define BFTM_PH_DONE 4'h1
`endif

// ===== test/bftm_unit_sva.sv
// Port checker for the bit-field test-and-modify unit
module bftm_unit_sva (
  // Clock and bus
  input wire sys_clk,
  input wire rst_b,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  // Destination port
  input wire dst_req,
  input wire dst_we,
  input wire [1:0] dst_space,
  input wire [15:0] dst_addr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Read pulse, one data cycle, then the write
  sequence rd_pulse;
    dst_req && !dst_we;
  endsequence
  sequence rmw_tail;
    !dst_req ##1 (dst_req && dst_we);
  endsequence
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_reply_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  rmw_order_a:
    assert property (rd_pulse |=> rmw_tail) else $error("write not after read");
  same_place_a:
    assert property (dst_req && dst_we |-> dst_addr == $past(dst_addr, 2)
      && dst_space == $past(dst_space, 2)) else $error("write elsewhere");
  rd_latency_a:
    assert property (rd_pulse |-> $past(wb_ack_o) || $past(wb_ack_o, 3)) else $error("read late");
  peri_region_a:
    assert property (dst_req && dst_space == 2'h1 |-> dst_addr[15:6] == 10'h3FF)
      else $error("peripheral address");
  sw_noport_a:
    assert property (dst_req && dst_space == 2'h2 |-> dst_addr[4:0] != 5'h19)
      else $error("status word on port");
  wr_alone_a:
    assert property (dst_req && dst_we |=> !dst_req [*2]) else $error("extra access");
endmodule // bftm_unit_sva
bind bftm_unit bftm_unit_sva chk_i (.sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .dst_req(dst_req), .dst_we(dst_we),
  .dst_space(dst_space), .dst_addr(dst_addr));

// ===== test/bftm_mem.sv
// Memory, peripheral and core register model behind the destination port
module bftm_mem (
  // Clock
  input wire sys_clk,
  // Destination access
  input wire dst_req,
  input wire dst_we,
  input wire [1:0] dst_space,
  input wire [15:0] dst_addr,
  input wire [15:0] dst_wdata,
  output wire [15:0] dst_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:3][0:65535];
  logic [15:0] rd_q = 16'h0000;
  logic rd_v = 1'b0;
  wire [15:0] loc = dst_space == 2'h2 ? {11'h000, dst_addr[4:0]} : dst_addr;
  // Answer only the cycle after a read; inverted data otherwise so stale data never passes
  always @(posedge sys_clk) begin
    rd_v <= dst_req && !dst_we;
    if (dst_req && !dst_we) begin
      rd_q <= mem[dst_space][loc];
    end
    if (dst_req && dst_we) begin
      mem[dst_space][loc] <= dst_wdata;
    end
  end
  assign dst_rdata = rd_v ? rd_q : ~rd_q;
endmodule // bftm_mem

// ===== test/bftm_unit_tb.sv
// Self-checking bench of the bit-field test-and-modify unit
module bftm_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic lim_event = 1'b0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] r;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, dst_req, dst_we;
  wire [1:0] dst_space;
  wire [15:0] dst_addr, dst_wdata, dst_rdata;
  int n_mismatch = 0;
  int compares = 0;
  // 20 MHz core clock
  always #25 sys_clk = ~sys_clk;
  bftm_unit dut (.sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dst_req(dst_req), .dst_we(dst_we),
    .dst_space(dst_space), .dst_addr(dst_addr), .dst_wdata(dst_wdata),
    .dst_rdata(dst_rdata), .lim_event(lim_event));
  bftm_mem mem_i (.sys_clk(sys_clk), .dst_req(dst_req), .dst_we(dst_we), .dst_space(dst_space),
    .dst_addr(dst_addr), .dst_wdata(dst_wdata), .dst_rdata(dst_rdata));
  task automatic conclude();
    if (n_mismatch == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Classic cycle; ack and read data taken at the rising edge that sees ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0000, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      n_mismatch++;
      conclude();
    end
    @(posedge sys_clk);
  endtask
  // Preset, run to completion, then judge value, flags and counts
  task automatic tc(input logic op, input logic [2:0] md, input logic [15:0] opd, msk,
      input logic [1:0] sp, input logic [15:0] ad, v0, sw0, input logic lim);
    logic isw;
    logic [15:0] nv, sw1;
    int n;
    isw = md == 3'h0 && opd[4:0] == 5'h19;
    nv = op ? ((isw ? sw0 : v0) & ~msk) : ((isw ? sw0 : v0) ^ msk);
    sw1 = isw ? nv : {sw0[15:7], sw0[6] | lim, sw0[5:1], (v0 & msk) == msk};
    mem_i.mem[sp][ad] = v0;
    wb(1'b1, 8'h04, msk);
    wb(1'b1, 8'h08, opd);
    wb(1'b1, 8'h14, sw0);
    wb(1'b1, 8'h00, {11'h000, md, op, 1'b1});
    lim_event <= lim;
    n = 0;
    do wb(1'b0, 8'h18, 16'h0000); while (r[0] !== 1'b0 && ++n < 20);
    if (r[0] !== 1'b0) begin
      n_mismatch++;
      conclude();
    end
    lim_event <= 1'b0;
    chk("counts", {10'h000, md == 3'h5 ? 2'h3 : 2'h2, md > 3'h2 ? 4'h6 : 4'h4},
      {10'h000, r[17:16], r[11:8]});
    chk("fault flag", 16'h0000, {15'h0000, r[1]});
    chk("dest value", isw ? v0 : nv, mem_i.mem[sp][ad]);
    wb(1'b0, 8'h14, 16'h0000);
    chk("status word", sw1, r[15:0]);
  endtask
  // Unknown form and busy-time writes refused; writes without both low byte lanes ignored
  task automatic refuse();
    mem_i.mem[0][16'h0300] = 16'h0000;
    wb(1'b1, 8'h04, 16'h00F0);
    wb(1'b1, 8'h08, 16'h0300);
    wb(1'b1, 8'h00, {11'h000, 3'h6, 2'b01});
    wb(1'b0, 8'h18, 16'h0000);
    chk("refused start", 16'h0090, {8'h00, r[17:16], r[11:8], r[1:0]});
    wb(1'b1, 8'h00, {11'h000, 3'h5, 2'b01});
    wb(1'b1, 8'h04, 16'h0F00);
    wb(1'b0, 8'h04, 16'h0000);
    chk("mask frozen", 16'h00F0, r[15:0]);
    chk("frozen dest", 16'h00F0, mem_i.mem[0][16'h0300]);
    wb_sel_i <= 4'hC;
    wb(1'b1, 8'h14, 16'hFFFF);
    wb_sel_i <= 4'hF;
    wb(1'b0, 8'h14, 16'h0000);
    chk("lane refused", 16'h0080, r[15:0]);
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    wb(1'b0, 8'h14, 16'h0000);
    chk("status reset", 16'h0000, r[15:0]);
    wb(1'b1, 8'h0C, 16'h0100);
    wb(1'b1, 8'h10, 16'h0200);
    tc(1'b0, 3'h1, 16'h0025, 16'h0310, 2'h0, 16'h0025, 16'h0FF0, 16'h0010, 1'b0);
    tc(1'b1, 3'h2, 16'h0022, 16'h0310, 2'h1, 16'hFFE2, 16'h7F95, 16'h0001, 1'b0);
    tc(1'b0, 3'h5, 16'h1234, 16'h0000, 2'h0, 16'h1234, 16'hA5A5, 16'h0000, 1'b1);
    tc(1'b1, 3'h3, 16'h0010, 16'hF000, 2'h0, 16'h0110, 16'hF0F0, 16'h0000, 1'b0);
    tc(1'b0, 3'h4, 16'h0005, 16'h00FF, 2'h0, 16'h01FB, 16'h00FF, 16'h0000, 1'b0);
    tc(1'b1, 3'h0, 16'h0002, 16'h8001, 2'h2, 16'h0002, 16'h8001, 16'h0000, 1'b0);
    tc(1'b0, 3'h0, 16'h0019, 16'h0080, 2'h3, 16'h0000, 16'h0000, 16'h0001, 1'b0);
    refuse();
    wb(1'b0, 8'h1C, 16'h0000);
    chk("unmapped read", 16'h0000, r[15:0]);
    conclude();
  end
  // Cut a hang short
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    conclude();
  end
endmodule // bftm_unit_tb
